// file: inc/pcc_pkg.sv
// Purpose: shared constants for the pulse count current control link
// Assumes: clk_sys at 100 MHz
// Notes:   long counts are module parameters derived from these times
package pcc_pkg;
  localparam int          CLK_MHZ        = 100;
  localparam int          CODE_W         = 5;
  localparam logic [4:0]  CODE_MAX       = 5'h1f;
  localparam logic [4:0]  CODE_ZERO      = 5'h00;
  localparam logic [4:0]  CODE_HIGH      = 5'h08;
  localparam int          SLEEP_US       = 100;
  localparam int          SETTLE_US      = 50;
  localparam int          TIMEOUT_MS     = 4000;
  localparam int          POR_MS         = 20;
  localparam int          STEP_MIN_NS    = 250;
  localparam int          SLEEP_CYC      = SLEEP_US * CLK_MHZ;
  localparam int          SETTLE_CYC     = SETTLE_US * CLK_MHZ;
  localparam int          TIMEOUT_CYC    = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int          POR_CYC        = POR_MS * 1000 * CLK_MHZ;
  localparam int          STEP_HALF_CYC  = (STEP_MIN_NS * CLK_MHZ + 1999) / 2000;
  localparam int          CNT_W          = 32;
  localparam logic [31:0] CNT_ZERO       = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE        = 32'h0000_0001;
endpackage : pcc_pkg

// file: inc/pcc_if.sv
// Purpose: two-pin link between host and current sink control
// Assumes: both pins are push-pull driven by the host
// Notes:   none
`timescale 1ns/100ps
interface pcc_if;
  logic out_on;
  logic pulse_step;
  modport host (output out_on, output pulse_step);
  modport dev  (input out_on, input pulse_step);
endinterface : pcc_if

// file: logic/pcc_dev.sv
// Purpose: device end, pulse counted current code with sleep, timeout, thermal gate
// Assumes: link pins asynchronous to clk_sys, synchronised here
// Notes:   sink_current_level is the code gated by driver enable
//
// Overview of operation
// (R01) each pulse rising edge adds one step
// (R02) code is five bits, zero to 31
// (R03) at 31 further edges ignored
// (R04) code only rises; lower via out_on cycle
// (R05) out_on low disables and clears code
// (R06) pulse low past threshold enters sleep
// (R07) code kept during sleep
// (R08) pulses in sleep add; they wake only if no timeout occurred
// (R09) code 8 or more times out to sleep
// (R10) timeout restarts only on out_on cycle
// (R11) host keeps pulse rate within limit
// (R12) driver enables settle time after last pulse
// (R13) over temperature gates driver, keeps code
// (R14) power on reset clears code and timer
// (R15) edges ignored during power on reset
// (R16) only rising edges count, not level
// (R17) host always drives both pins
// (R18) power on reset lasts fixed interval
// (R19) low time restarts each edge; timebase counts
`timescale 1ns/100ps
module pcc_dev #(
  parameter int SLEEP_CYC   = pcc_pkg::SLEEP_CYC,
  parameter int SETTLE_CYC  = pcc_pkg::SETTLE_CYC,
  parameter int TIMEOUT_CYC = pcc_pkg::TIMEOUT_CYC,
  parameter int POR_CYC     = pcc_pkg::POR_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // link
  pcc_if.dev               link,
  // thermal comparator, asynchronous
  input  wire logic        over_temp,
  // driver side
  output logic [4:0]       sink_current_level,
  output logic             driver_on,
  output logic             sleeping,
  output logic             por_busy
);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic [1:0] on_sync_ff, st_sync_ff, ot_sync_ff;
  logic       on_s, st_s, ot_s;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      on_sync_ff <= 2'h0;
      st_sync_ff <= 2'h0;
      ot_sync_ff <= 2'h0;
    end
    else
    begin
      on_sync_ff <= {on_sync_ff[0], link.out_on};
      st_sync_ff <= {st_sync_ff[0], link.pulse_step};
      ot_sync_ff <= {ot_sync_ff[0], over_temp};
    end
  end

  assign on_s = on_sync_ff[1];
  assign st_s = st_sync_ff[1];
  assign ot_s = ot_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////
  // control state
  logic [4:0]  code_ff, nxt_code;
  logic [31:0] por_ff, nxt_por;
  logic [31:0] low_ff, nxt_low;
  logic [31:0] tmo_ff, nxt_tmo;
  logic [31:0] set_ff, nxt_set;
  logic        sleep_ff, nxt_sleep;
  logic        tmo_done_ff, nxt_tmo_done;
  logic        st_prev_ff, nxt_st_prev;
  logic        rise;

  function automatic logic [31:0] cnt_inc(input logic [31:0] c, input int lim);
    cnt_inc = (c >= 32'(lim)) ? c : c + pcc_pkg::CNT_ONE;
  endfunction : cnt_inc

  // st_prev tracks level even in reset window so a static high never counts
  assign rise = st_s & ~st_prev_ff; // R16

  always_comb
  begin
    nxt_code     = code_ff;
    nxt_por      = cnt_inc(por_ff, POR_CYC); // R18
    nxt_low      = low_ff;
    nxt_tmo      = tmo_ff;
    nxt_set      = set_ff;
    nxt_sleep    = sleep_ff;
    nxt_tmo_done = tmo_done_ff;
    nxt_st_prev  = st_s;
    if (por_ff < 32'(POR_CYC))
    begin
      // R15
      nxt_code = pcc_pkg::CODE_ZERO;
      nxt_tmo  = pcc_pkg::CNT_ZERO;
    end
    else if (!on_s)
    begin
      nxt_code     = pcc_pkg::CODE_ZERO; // R05 R04
      nxt_tmo      = pcc_pkg::CNT_ZERO; // R10
      nxt_tmo_done = 1'b0; // R10
      nxt_sleep    = 1'b0;
      nxt_low      = pcc_pkg::CNT_ZERO;
      nxt_set      = pcc_pkg::CNT_ZERO;
    end
    else
    begin
      if (rise)
      begin
        if (code_ff != pcc_pkg::CODE_MAX)
          nxt_code = code_ff + 5'h01; // R01 R02 R03
        nxt_low = pcc_pkg::CNT_ZERO; // R19
        nxt_set = pcc_pkg::CNT_ZERO; // R12
        if (!tmo_done_ff)
          nxt_sleep = 1'b0; // R08
      end
      else
      begin
        nxt_set = cnt_inc(set_ff, SETTLE_CYC);
        if (!st_s)
        begin
          nxt_low = cnt_inc(low_ff, SLEEP_CYC); // R19
          if (low_ff >= 32'(SLEEP_CYC) && code_ff != pcc_pkg::CODE_ZERO)
            nxt_sleep = 1'b1; // R06 R07
        end
      end
      if (code_ff >= pcc_pkg::CODE_HIGH && !sleep_ff)
      begin
        nxt_tmo = cnt_inc(tmo_ff, TIMEOUT_CYC); // R09
        if (tmo_ff >= 32'(TIMEOUT_CYC))
        begin
          nxt_sleep    = 1'b1; // R09
          nxt_tmo_done = 1'b1; // R10
        end
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      code_ff     <= pcc_pkg::CODE_ZERO; // R14
      por_ff      <= pcc_pkg::CNT_ZERO;
      low_ff      <= pcc_pkg::CNT_ZERO;
      tmo_ff      <= pcc_pkg::CNT_ZERO; // R14
      set_ff      <= pcc_pkg::CNT_ZERO;
      sleep_ff    <= 1'b0;
      tmo_done_ff <= 1'b0;
      st_prev_ff  <= 1'b0;
    end
    else
    begin
      code_ff     <= nxt_code;
      por_ff      <= nxt_por;
      low_ff      <= nxt_low;
      tmo_ff      <= nxt_tmo;
      set_ff      <= nxt_set;
      sleep_ff    <= nxt_sleep;
      tmo_done_ff <= nxt_tmo_done;
      st_prev_ff  <= nxt_st_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // driver outputs, registered
  logic [4:0] lvl_ff, nxt_lvl;
  logic       drv_ff, nxt_drv;

  always_comb
  begin
    nxt_drv = on_s && !sleep_ff && !ot_s && (code_ff != pcc_pkg::CODE_ZERO)
              && (set_ff >= 32'(SETTLE_CYC)) && (por_ff >= 32'(POR_CYC)); // R12 R13 R05 R06
    nxt_lvl = nxt_drv ? code_ff : pcc_pkg::CODE_ZERO; // R13
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      lvl_ff <= pcc_pkg::CODE_ZERO;
      drv_ff <= 1'b0;
    end
    else
    begin
      lvl_ff <= nxt_lvl;
      drv_ff <= nxt_drv;
    end
  end

  assign sink_current_level = lvl_ff;
  assign driver_on          = drv_ff;
  assign sleeping           = sleep_ff;
  assign por_busy           = (por_ff < 32'(POR_CYC));

endmodule : pcc_dev

// file: logic/pcc_host.sv
// Purpose: host end, drives out_on and pulse_step from simple commands
// Assumes: commands from logic on clk_sys
// Notes:   pulses spaced to respect the maximum step rate
`timescale 1ns/100ps
module pcc_host #(
  parameter int HALF_CYC = pcc_pkg::STEP_HALF_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // user commands
  input  wire logic        enable,
  input  wire logic        send_valid,
  input  wire logic [4:0]  send_count,
  output logic             send_ready,
  // link
  pcc_if.host              link
);

  typedef enum logic [1:0] {H_IDLE, H_HIGH, H_LOW} pcc_hst_t;

  pcc_hst_t    st_ff, nxt_st;
  logic [4:0]  left_ff, nxt_left;
  logic [31:0] cnt_ff, nxt_cnt;
  logic        on_ff, nxt_on;
  logic        ps_ff, nxt_ps;

  always_comb
  begin
    nxt_st   = st_ff;
    nxt_left = left_ff;
    nxt_cnt  = cnt_ff;
    nxt_on   = enable; // R17 R04 R10
    nxt_ps   = ps_ff;
    unique case (st_ff)
      H_IDLE:
        if (send_valid && send_count != pcc_pkg::CODE_ZERO)
        begin
          nxt_st   = H_HIGH;
          nxt_left = send_count;
          nxt_ps   = 1'b1;
          nxt_cnt  = pcc_pkg::CNT_ZERO;
        end
      H_HIGH:
        if (cnt_ff + pcc_pkg::CNT_ONE >= 32'(HALF_CYC)) // R11
        begin
          nxt_st  = H_LOW;
          nxt_ps  = 1'b0;
          nxt_cnt = pcc_pkg::CNT_ZERO;
          nxt_left = left_ff - 5'h01;
        end
        else
          nxt_cnt = cnt_ff + pcc_pkg::CNT_ONE;
      H_LOW:
        if (cnt_ff + pcc_pkg::CNT_ONE >= 32'(HALF_CYC)) // R11
        begin
          nxt_cnt = pcc_pkg::CNT_ZERO;
          if (left_ff == pcc_pkg::CODE_ZERO)
            nxt_st = H_IDLE;
          else
          begin
            nxt_st = H_HIGH;
            nxt_ps = 1'b1;
          end
        end
        else
          nxt_cnt = cnt_ff + pcc_pkg::CNT_ONE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      st_ff   <= H_IDLE;
      left_ff <= pcc_pkg::CODE_ZERO;
      cnt_ff  <= pcc_pkg::CNT_ZERO;
      on_ff   <= 1'b0;
      ps_ff   <= 1'b0;
    end
    else
    begin
      st_ff   <= nxt_st;
      left_ff <= nxt_left;
      cnt_ff  <= nxt_cnt;
      on_ff   <= nxt_on;
      ps_ff   <= nxt_ps;
    end
  end

  assign send_ready      = (st_ff == H_IDLE);
  assign link.out_on     = on_ff;
  assign link.pulse_step = ps_ff;

endmodule : pcc_host

// file: test/pcc_monitor.sv
// Purpose: checker beside the link between host and device ends
// Assumes: device built with short sleep, settle, timeout and power-on counts
// Notes:   all properties share clk_sys and resetn
`timescale 1ns/100ps
module pcc_monitor (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // link and driver side
  input wire logic       out_on,
  input wire logic       pulse_step,
  input wire logic       over_temp,
  input wire logic [4:0] sink_current_level,
  input wire logic       driver_on,
  input wire logic       sleeping,
  input wire logic       por_busy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_off; sink_current_level == 5'h00 && !driver_on; endsequence
  sequence s_on2; driver_on ##1 driver_on; endsequence
  property p_sat; sink_current_level == 5'h1f && out_on |=> sink_current_level inside {5'h1f, 5'h00}; endproperty
  property p_rise; s_on2 |-> sink_current_level >= $past(sink_current_level); endproperty
  property p_shut; !out_on |-> ##[1:6] s_off; endproperty
  property p_sleep; $rose(sleeping) |-> ##[0:1] s_off; endproperty
  property p_settle; $rose(pulse_step) |=> !$rose(driver_on) [*8]; endproperty
  property p_hot; over_temp |-> ##[1:6] !driver_on; endproperty
  property p_por; por_busy |-> s_off; endproperty
  property p_init; $rose(resetn) |-> sink_current_level == 5'h00 && !driver_on && !sleeping; endproperty
  a_sat: assert property (p_sat) else $error("code left full scale");
  a_rise: assert property (p_rise) else $error("code fell while driving");
  a_shut: assert property (p_shut) else $error("driver on while disabled");
  a_sleep: assert property (p_sleep) else $error("driver on in sleep");
  a_settle: assert property (p_settle) else $error("driver enabled before settling");
  a_hot: assert property (p_hot) else $error("driver on while hot");
  a_por: assert property (p_por) else $error("output during power-on");
  a_init: assert property (p_init) else $error("outputs not cleared by reset");
endmodule : pcc_monitor

// file: test/pulse_count_current_control_test.sv
// Purpose: end to end test of host and device ends against a model
// Assumes: shortened counts: sleep 100, settle 10, timeout 2000, power-on 20
// Notes:   model keeps code, sleep flag and timeout lock
`timescale 1ns/100ps
module pulse_count_current_control_test;
  logic       clk_sys    = 1'b0;
  logic       resetn     = 1'b0;
  logic       enable     = 1'b1;
  logic       send_valid = 1'b0;
  logic [4:0] send_count = 5'h00;
  logic       over_temp  = 1'b0;
  logic       send_ready;
  logic [4:0] sink_current_level;
  logic       driver_on;
  logic       sleeping;
  logic       por_busy;
  logic       slp        = 1'b0;
  logic       tmo        = 1'b0;
  int         code       = 0;
  int         num_errors = 0;
  int         checks     = 0;
  pcc_if      link ();
  always #5 clk_sys = ~clk_sys;
  pcc_host pcc_host_inst (.clk_sys(clk_sys), .resetn(resetn), .enable(enable), .send_valid(send_valid),
    .send_count(send_count), .send_ready(send_ready), .link(link));
  pcc_dev #(.SLEEP_CYC(100), .SETTLE_CYC(10), .TIMEOUT_CYC(2000), .POR_CYC(20)) pcc_dev_inst (
    .clk_sys(clk_sys), .resetn(resetn), .link(link), .over_temp(over_temp),
    .sink_current_level(sink_current_level), .driver_on(driver_on), .sleeping(sleeping), .por_busy(por_busy));
  pcc_monitor pcc_monitor_inst (.clk_sys(clk_sys), .resetn(resetn), .out_on(link.out_on),
    .pulse_step(link.pulse_step), .over_temp(over_temp), .sink_current_level(sink_current_level),
    .driver_on(driver_on), .sleeping(sleeping), .por_busy(por_busy));
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_cyc
  task automatic chk(input logic [6:0] exp);
    checks++;
    if ({driver_on, sleeping, sink_current_level} !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t exp %h got %h", $time, exp, {driver_on, sleeping, sink_current_level});
    end
  endtask : chk
  function automatic logic [6:0] exp_v();
    return {!slp && code != 0, slp, slp ? 5'h00 : code[4:0]};
  endfunction : exp_v
  task automatic send(input int n, input bit live);
    int k;
    send_valid <= 1'b1;
    send_count <= n[4:0];
    @(posedge clk_sys);
    send_valid <= 1'b0;
    @(posedge clk_sys);
    for (k = 0; k < 2000 && send_ready !== 1'b1; k++)
      @(posedge clk_sys);
    if (send_ready !== 1'b1)
      num_errors++;
    if (live)
      code = (code + n > 31) ? 31 : code + n;
    if (live && !tmo)
      slp = 1'b0;
  endtask : send
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'haf6d));
    wait_cyc(20);
    resetn <= 1'b1;
    send(1, 0);
    for (int i = 0; i < 100 && por_busy !== 1'b0; i++)
      @(posedge clk_sys);
    if (por_busy !== 1'b0)
      num_errors++;
    wait_cyc(20);
    chk(exp_v());
    $display("test 1 done");
    send($urandom_range(7, 1), 1);
    wait_cyc(10);
    chk(exp_v());
    over_temp <= 1'b1;
    wait_cyc(6);
    chk(7'h00);
    over_temp <= 1'b0;
    wait_cyc(20);
    chk(exp_v());
    wait_cyc(80);
    slp = 1'b1;
    chk(exp_v());
    send($urandom_range(7, 1), 1);
    wait_cyc(10);
    chk(exp_v());
    $display("test 2 done");
    send(31, 1);
    wait_cyc(10);
    chk(exp_v());
    repeat (3) send(31, 1);
    tmo = 1'b1;
    slp = 1'b1;
    wait_cyc(10);
    chk(exp_v());
    send(1, 1);
    wait_cyc(10);
    chk(exp_v());
    $display("test 3 done");
    enable <= 1'b0;
    wait_cyc(10);
    code = 0;
    slp = 1'b0;
    tmo = 1'b0;
    chk(exp_v());
    enable <= 1'b1;
    wait_cyc(10);
    send(2, 1);
    wait_cyc(10);
    chk(exp_v());
    $display("test 4 done");
    finish_test();
  end
  initial
  begin
    wait_cyc(20000);
    num_errors++;
    finish_test();
  end
endmodule : pulse_count_current_control_test
